// ==== verilog/ext_bus_pins.v ====
`timescale 1ns/1ns
`include "ext_bus_map.vh"
module ext_bus_pins #(
  parameter ODD_PARITY = 1
) (
  core_clk,
  reset,
  ce,
  req_valid,
  req_ready,
  req_write,
  req_iack,
  req_size,
  req_addr,
  req_fc,
  req_level,
  req_wdata,
  rsp_valid,
  rsp_rdata,
  rsp_port_size,
  rsp_parity_err,
  half_width,
  cs_enable,
  cs_base,
  cs_mask,
  dup_enable,
  sel7_is_iack,
  address,
  function_code_lines,
  addr_strobe_n,
  data_strobe_n,
  read_not_write,
  data_in,
  data_out,
  data_hi_oe,
  data_lo_oe,
  lane_parity_in,
  lane_parity_out,
  lane_parity_oe,
  size_acknowledge_n,
  boot_select_n,
  chip_select_n,
  select_seven_n,
  row_select1_dup_n,
  row_select2_dup_n,
  level_ack_strobes_n
);
  input  wire         core_clk;
  input  wire         reset;
  input  wire         ce;
  input  wire         req_valid;
  output wire         req_ready;
  input  wire         req_write;
  input  wire         req_iack;
  input  wire [1:0]   req_size;
  input  wire [31:0]  req_addr;
  input  wire [3:0]   req_fc;
  input  wire [2:0]   req_level;
  input  wire [31:0]  req_wdata;
  output reg          rsp_valid;
  output reg  [31:0]  rsp_rdata;
  output reg  [1:0]   rsp_port_size;
  output reg          rsp_parity_err;
  output reg          half_width;
  input  wire [7:0]   cs_enable;
  input  wire [127:0] cs_base;
  input  wire [127:0] cs_mask;
  input  wire         dup_enable;
  input  wire         sel7_is_iack;
  output reg  [31:0]  address;
  output reg  [3:0]   function_code_lines;
  output reg          addr_strobe_n;
  output reg          data_strobe_n;
  output reg          read_not_write;
  input  wire [31:0]  data_in;
  output reg  [31:0]  data_out;
  output reg          data_hi_oe;
  output reg          data_lo_oe;
  input  wire [3:0]   lane_parity_in;
  output reg  [3:0]   lane_parity_out;
  output reg  [3:0]   lane_parity_oe;
  input  wire [1:0]   size_acknowledge_n;
  output reg          boot_select_n;
  output reg  [6:1]   chip_select_n;
  output reg          select_seven_n;
  output reg          row_select1_dup_n;
  output reg          row_select2_dup_n;
  output reg  [6:1]   level_ack_strobes_n;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ADDR = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  reg  [3:0]  state;
  reg  [3:0]  next_state;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [37:0] pin_meta;
  reg  [37:0] pin_sync;
  wire [31:0] bus_data;
  wire [3:0]  bus_parity;
  wire [1:0]  bus_ack_n;

  always @(posedge core_clk) begin
    if (ce) begin
      pin_meta <= {size_acknowledge_n, lane_parity_in, data_in};
      pin_sync <= pin_meta;
    end
  end

  assign bus_data   = pin_sync[31:0];
  assign bus_parity = pin_sync[35:32];
  assign bus_ack_n  = pin_sync[37:36];

  // ----------------------------------------------------------------
  // Width strap
  // ----------------------------------------------------------------
  // Sampled on every clock-enabled edge while reset is held, frozen at release
  always @(posedge core_clk) begin
    if (ce && reset) begin
      half_width <= ~bus_parity[`STRAP_LANE]; // [R4] [R5]
    end
  end

  // ----------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------
  reg  [7:0]  hit;
  reg  [7:0]  pick;
  integer     k;

  always @* begin
    hit  = 8'h00;
    pick = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      hit[k] = cs_enable[k] &
               (((req_addr[`SEL_ADDR_MSB:`SEL_ADDR_LSB] ^
                  cs_base[16*k +: 16]) & cs_mask[16*k +: 16])
                == 16'h0000); // [R6]
    end
    // Select zero answers everywhere until it is programmed
    if (!cs_enable[0]) begin
      hit[0] = 1'b1; // [R6]
    end
    for (k = 7; k >= 0; k = k - 1) begin
      if (hit[k]) begin
        pick = 8'h00;
        pick[k] = 1'b1;
      end
    end
    if (req_iack) begin
      pick = 8'h00;
    end
    // With the shared pin given to acknowledge, range seven is unused
    if (sel7_is_iack) begin
      pick[7] = 1'b0; // [R8]
    end
  end

  // ----------------------------------------------------------------
  // Lane use and parity
  // ----------------------------------------------------------------
  wire        wide_size;
  wire        use_lo;
  wire [3:0]  wr_parity;
  wire [3:0]  rd_parity;
  reg         cur_lo;
  reg         cur_write;
  reg  [7:0]  cur_level;
  reg  [7:0]  cur_sel;

  assign wide_size = (req_size == `SIZE_LONG) ||
                     (req_size == `SIZE_TRIPLE);
  assign use_lo    = wide_size & ~half_width; // [R1] [R2]

  lane_parity #(
    .LANES (4),
    .ODD   (ODD_PARITY)
  ) u_wr_parity (
    .data   (req_wdata),
    .parity (wr_parity)
  );

  lane_parity #(
    .LANES (4),
    .ODD   (ODD_PARITY)
  ) u_rd_parity (
    .data   (bus_data),
    .parity (rd_parity)
  );

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  wire        acked;

  assign acked     = (bus_ack_n != 2'b11); // [R14]
  assign req_ready = state[0];

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (acked) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      state               <= ST_IDLE;
      address             <= 32'h00000000;
      function_code_lines <= 4'h0;
      addr_strobe_n       <= 1'b1;
      data_strobe_n       <= 1'b1;
      read_not_write      <= 1'b1;
      data_out            <= 32'h00000000;
      data_hi_oe          <= 1'b0;
      data_lo_oe          <= 1'b0;
      lane_parity_out     <= 4'h0;
      lane_parity_oe      <= 4'h0;
      cur_lo              <= 1'b0;
      cur_write           <= 1'b0;
      cur_level           <= 8'h00;
      cur_sel             <= 8'h00;
      rsp_valid           <= 1'b0;
      rsp_rdata           <= 32'h00000000;
      rsp_port_size       <= `PORT_NONE;
      rsp_parity_err      <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_valid) begin
            cur_write      <= req_write & ~req_iack;
            cur_lo         <= use_lo;
            cur_sel        <= pick;
            read_not_write <= ~(req_write & ~req_iack); // [R9]
            cur_level      <= 8'h00;
            if (req_iack) begin
              function_code_lines <= `FC_CPU_SPACE; // [R9]
              address <= 32'hffffffff; // [R12]
              address[`SPACE_TYPE_MSB:`SPACE_TYPE_LSB] <=
                `SPACE_TYPE_IACK; // [R11]
              address[`LEVEL_MSB:`LEVEL_LSB] <= req_level; // [R10]
              if (req_level != 3'h0) begin
                // One-hot so at most one level strobe fires
                cur_level <= 8'h01 << req_level; // [R15]
              end
            end else begin
              function_code_lines <= req_fc;
              address             <= req_addr;
            end
            data_out        <= req_wdata;
            lane_parity_out <= wr_parity; // [R3]
          end
        end
        ST_ADDR: begin
          addr_strobe_n <= 1'b0;
          data_strobe_n <= 1'b0;
          data_hi_oe    <= cur_write;
          data_lo_oe    <= cur_write & cur_lo; // [R1] [R2]
          lane_parity_oe <= {{2{cur_write & cur_lo}},
                             {2{cur_write}}}; // [R3] [R4]
        end
        ST_WAIT: begin
          if (acked) begin
            // Acknowledge reads complete exactly like data reads
            rsp_rdata <= cur_lo ? bus_data
                                : {bus_data[31:16], 16'h0000}; // [R13]
            rsp_port_size  <= bus_ack_n;
            rsp_parity_err <= ~cur_write &
              (((rd_parity ^ bus_parity) &
                {{2{cur_lo}}, 2'b11}) != 4'h0); // [R3]
            rsp_valid      <= 1'b1; // [R14]
          end
        end
        ST_DONE: begin
          addr_strobe_n  <= 1'b1;
          data_strobe_n  <= 1'b1;
          data_hi_oe     <= 1'b0;
          data_lo_oe     <= 1'b0;
          lane_parity_oe <= 4'h0;
          read_not_write <= 1'b1;
          cur_sel        <= 8'h00;
          cur_level      <= 8'h00;
        end
        default: begin
          addr_strobe_n <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Select and strobe pins
  // ----------------------------------------------------------------
  wire        strobe_on;

  assign strobe_on = state[2] | state[3];

  always @(posedge core_clk) begin
    if (reset) begin
      boot_select_n       <= 1'b1;
      chip_select_n       <= 6'h3f;
      select_seven_n      <= 1'b1;
      row_select1_dup_n   <= 1'b1;
      row_select2_dup_n   <= 1'b1;
      level_ack_strobes_n <= 6'h3f;
    end else if (ce) begin
      boot_select_n <= ~(strobe_on & cur_sel[0]); // [R6]
      chip_select_n <= ~({6{strobe_on}} & cur_sel[6:1]); // [R6]
      row_select1_dup_n <= ~(dup_enable & strobe_on &
                             cur_sel[1]); // [R7]
      row_select2_dup_n <= ~(dup_enable & strobe_on &
                             cur_sel[2]); // [R7]
      level_ack_strobes_n <= ~({6{strobe_on}} &
                               cur_level[6:1]); // [R10] [R15]
      if (sel7_is_iack) begin
        select_seven_n <= ~(strobe_on & cur_level[7]); // [R8]
      end else begin
        select_seven_n <= ~(strobe_on & cur_sel[7]); // [R8]
      end
    end
  end

endmodule

// ==== common/ext_bus_map.vh ====
// Summary of operation
// R1: Lower data half used only long/three-byte transfers.
// R2: Half-width mode keeps lower data lines undriven.
// R3: Parity lane0 bits 31-24 through lane3 bits 7-0.
// R4: Lane3 parity pin is strap during reset.
// R5: Strap high or floating selects 32-bit bus.
// R6: Selects follow address ranges; select zero boots.
// R7: Optionally copy row selects 1, 2 to duplicates.
// R8: Select seven pin may be level-7 acknowledge.
// R9: Acknowledge cycle reads CPU space, codes 0111.
// R10: Acknowledge drives level on A3-A1, matching strobe.
// R11: Acknowledge drives space type A19-A16 all ones.
// R12: Acknowledge drives all other address bits high.
// R13: Responder places vector number on data bus.
// R14: Acknowledge ends by size acknowledge like reads.
// R15: Only one level acknowledge strobe active.
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define FC_CPU_SPACE      4'h7
`define SPACE_TYPE_IACK   4'hf
`define SPACE_TYPE_LSB    16
`define SPACE_TYPE_MSB    19
`define LEVEL_LSB         1
`define LEVEL_MSB         3
`define SIZE_LONG         2'h0
`define SIZE_BYTE         2'h1
`define SIZE_WORD         2'h2
`define SIZE_TRIPLE       2'h3
`define PORT_32           2'h0
`define PORT_8            2'h1
`define PORT_16           2'h2
`define PORT_NONE         2'h3

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SEL_ADDR_LSB      16
`define SEL_ADDR_MSB      31
`define STRAP_LANE        3
`define SYNC_STAGES       2
`define RESET_HALF_WIDTH  1'b0

`endif

// ==== verilog/lane_parity.v ====
`timescale 1ns/1ns
module lane_parity #(
  parameter LANES = 4,
  parameter ODD   = 1
) (
  data,
  parity
);
  input  wire [8*LANES-1:0] data;
  output wire [LANES-1:0]   parity;

  // ----------------------------------------------------------------
  // One parity bit per byte lane, lane zero on the top byte
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < LANES; i = i + 1) begin : g_lane
      assign parity[i] = (^data[8*(LANES-i)-1 -: 8])
                         ^ (ODD != 0); // [R3]
    end
  endgenerate

endmodule

// ==== dv/ext_bus_pins_sva.sv ====
`timescale 1ns/1ns
module ext_bus_pins_sva (
  input wire        core_clk,
  input wire        reset,
  input wire        ce,
  input wire        req_valid,
  input wire        req_ready,
  input wire        req_write,
  input wire        req_iack,
  input wire [1:0]  req_size,
  input wire [2:0]  req_level,
  input wire        rsp_valid,
  input wire        half_width,
  input wire        dup_enable,
  input wire        sel7_is_iack,
  input wire [31:0] address,
  input wire [3:0]  function_code_lines,
  input wire        addr_strobe_n,
  input wire        data_strobe_n,
  input wire        read_not_write,
  input wire [31:0] data_out,
  input wire        data_hi_oe,
  input wire        data_lo_oe,
  input wire [3:0]  lane_parity_in,
  input wire [3:0]  lane_parity_out,
  input wire [3:0]  lane_parity_oe,
  input wire        boot_select_n,
  input wire [6:1]  chip_select_n,
  input wire        select_seven_n,
  input wire        row_select1_dup_n,
  input wire        row_select2_dup_n,
  input wire [6:1]  level_ack_strobes_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  sequence take_s;
    ce && req_valid && req_ready;
  endsequence
  property iack_addr_p;
    logic [2:0] lv;
    (take_s ##0 req_iack, lv = req_level) |-> ##3
      address == {12'hfff, 4'hf, 12'hfff, lv, 1'b1} &&
      function_code_lines == 4'h7 && read_not_write && !data_hi_oe;
  endproperty
  property iack_strobe_p;
    logic [2:0] lv;
    (take_s ##0 req_iack, lv = req_level) |-> ##4
      (&chip_select_n) && boot_select_n && (lv == 3'h7 ?
      select_seven_n == !sel7_is_iack :
      (lv == 3'h0 || !level_ack_strobes_n[lv]));
  endproperty
  property lo_size_p;
    logic [1:0] sz;
    (take_s ##0 (req_write && !req_iack), sz = req_size) |-> ##3
      data_hi_oe &&
      data_lo_oe == (!half_width && (sz == 2'h0 || sz == 2'h3));
  endproperty
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  iack_addr_a: assert property (iack_addr_p)
    else $error("acknowledge cycle address or code wrong");
  iack_strobe_a: assert property (iack_strobe_p)
    else $error("acknowledge strobe or select wrong");
  one_level_a: assert property (
    $onehot0({~level_ack_strobes_n, sel7_is_iack && !select_seven_n}))
    else $error("more than one level strobe active");
  half_lo_a: assert property (half_width |-> !data_lo_oe)
    else $error("lower data driven in half width mode");
  lo_size_a: assert property (lo_size_p)
    else $error("lower data enable does not match size");
  dup_copy_a: assert property ($stable(dup_enable) |->
    row_select1_dup_n == (chip_select_n[1] | !dup_enable) &&
    row_select2_dup_n == (chip_select_n[2] | !dup_enable))
    else $error("duplicate row select mismatch");
  parity_lane_a: assert property (
    (!lane_parity_oe[0] || lane_parity_out[0] == ~^data_out[31:24]) &&
    (!lane_parity_oe[3] || lane_parity_out[3] == ~^data_out[7:0]))
    else $error("driven lane parity wrong");
  strap_mode_a: assert property ($fell(reset) |->
    half_width == !$past(lane_parity_in[3]))
    else $error("bus width not taken from strap");
  done_release_a: assert property (rsp_valid |->
    ##[1:2] (addr_strobe_n && data_strobe_n))
    else $error("strobes not released after completion");
endmodule
bind ext_bus_pins ext_bus_pins_sva i_sva (.core_clk, .reset, .ce,
  .req_valid, .req_ready, .req_write, .req_iack, .req_size, .req_level,
  .rsp_valid, .half_width, .dup_enable, .sel7_is_iack, .address,
  .function_code_lines, .addr_strobe_n, .data_strobe_n, .read_not_write,
  .data_out, .data_hi_oe, .data_lo_oe, .lane_parity_in, .lane_parity_out,
  .lane_parity_oe, .boot_select_n, .chip_select_n, .select_seven_n,
  .row_select1_dup_n, .row_select2_dup_n, .level_ack_strobes_n);

// ==== dv/bus_responder.sv ====
`timescale 1ns/1ns
module bus_responder (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        strap_low,
  input  wire [1:0]  ack_port,
  input  wire [1:0]  ack_delay,
  input  wire [31:0] address,
  input  wire [3:0]  function_code_lines,
  input  wire        addr_strobe_n,
  input  wire        read_not_write,
  input  wire [31:0] data_out,
  input  wire        data_hi_oe,
  input  wire        data_lo_oe,
  input  wire [3:0]  lane_parity_out,
  input  wire [3:0]  lane_parity_oe,
  output logic [31:0] data_in,
  output logic [3:0]  lane_parity_in,
  output wire [1:0]  size_acknowledge_n
);
  logic [1:0]  ack_n = 2'h3;
  logic [1:0]  cnt = 2'h0;
  logic        resp = 1'b0;
  logic [31:0] last_d = 32'h0;
  logic [3:0]  last_p = 4'h0;
  wire  [3:0]  drv = resp && read_not_write ?
                     {{2{ack_port == 2'h0}}, 2'b11} : 4'h0;
  wire  [31:0] rd = function_code_lines == 4'h7 ?
                    {4{5'h08, address[3:1]}} :
                    {address[15:0], ~address[15:0]};
  assign size_acknowledge_n = ack_n;
  always @(posedge core_clk) begin
    last_d <= data_in;
    last_p <= lane_parity_in;
    if (addr_strobe_n) begin
      cnt <= 2'h0;
      resp <= 1'b0;
      ack_n <= 2'h3;
    end else if (cnt == ack_delay) begin
      resp <= 1'b1;
      ack_n <= ack_port;
    end else
      cnt <= cnt + 2'h1;
  end
  // Released lines show the inverse of their last level; parity lane 3 shows the strap during reset
  always @* begin
    data_in[31:16] = data_hi_oe ? data_out[31:16] :
                     drv[0] ? rd[31:16] : ~last_d[31:16];
    data_in[15:0] = data_lo_oe ? data_out[15:0] :
                    drv[3] ? rd[15:0] : ~last_d[15:0];
    for (int i = 0; i < 4; i++)
      lane_parity_in[i] = lane_parity_oe[i] ? lane_parity_out[i] :
        (reset && i == 3) ? !strap_low :
        drv[i] ? ~^data_in[31-8*i -: 8] : ~last_p[i];
  end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 0, reset = 1, ce = 1, req_valid = 0, req_write = 0;
  logic req_iack = 0, dup_enable = 0, sel7_is_iack = 0, strap_low = 0;
  logic [1:0] req_size = 0, ack_port = 0, ack_delay = 0;
  logic [31:0] req_addr = 0, req_wdata = 0, seen_addr, seen_data;
  logic [3:0] req_fc = 0;
  logic [2:0] req_level = 0;
  logic [7:0] seen_sel;
  logic [7:0] cs_enable = 8'h07;
  logic [127:0] cs_base = 128'h2000_1000_0000;
  logic [127:0] cs_mask = 128'hffff_ffff_ffff;
  wire req_ready, rsp_valid, rsp_parity_err, half_width, addr_strobe_n;
  wire data_strobe_n, read_not_write, data_hi_oe, data_lo_oe;
  wire boot_select_n, select_seven_n, row_select1_dup_n, row_select2_dup_n;
  wire [31:0] rsp_rdata, address, data_in, data_out;
  wire [1:0] rsp_port_size, size_acknowledge_n;
  wire [3:0] function_code_lines, lane_parity_in, lane_parity_out;
  wire [3:0] lane_parity_oe;
  wire [6:1] chip_select_n, level_ack_strobes_n;
  int err_count = 0, n_tests = 0, i, k;
  ext_bus_pins i_dut (.core_clk, .reset, .ce, .req_valid, .req_ready,
    .req_write, .req_iack, .req_size, .req_addr, .req_fc, .req_level,
    .req_wdata, .rsp_valid, .rsp_rdata, .rsp_port_size, .rsp_parity_err,
    .half_width, .cs_enable, .cs_base, .cs_mask, .dup_enable, .sel7_is_iack,
    .address, .function_code_lines, .addr_strobe_n, .data_strobe_n,
    .read_not_write, .data_in, .data_out, .data_hi_oe, .data_lo_oe,
    .lane_parity_in, .lane_parity_out, .lane_parity_oe, .size_acknowledge_n,
    .boot_select_n, .chip_select_n, .select_seven_n, .row_select1_dup_n,
    .row_select2_dup_n, .level_ack_strobes_n);
  bus_responder i_resp (.core_clk, .reset, .strap_low, .ack_port,
    .ack_delay, .address, .function_code_lines, .addr_strobe_n,
    .read_not_write, .data_out, .data_hi_oe, .data_lo_oe, .lane_parity_out,
    .lane_parity_oe, .data_in, .lane_parity_in, .size_acknowledge_n);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (!addr_strobe_n) begin
    seen_addr <= address;
    seen_data <= data_out;
    seen_sel <= seen_sel & {select_seven_n, chip_select_n, boot_select_n};
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    @(posedge core_clk);
    reset <= 1;
    strap_low <= s;
    ack_port <= s ? 2'h2 : 2'h0;
    repeat (4) @(posedge core_clk);
    reset <= 0;
    @(negedge core_clk);
    check("half", half_width, s);
  endtask
  function automatic logic [31:0] exp_rdata(input logic iack,
      input logic [1:0] sz, input logic [31:0] a, input logic [2:0] lv);
    logic [31:0] d;
    d = iack ? {4{5'h08, lv}} : {a[15:0], ~a[15:0]};
    if (strap_low || !(sz == 0 || sz == 3)) d[15:0] = 16'h0;
    return d;
  endfunction
  function automatic logic [31:0] exp_addr(input logic iack,
      input logic [31:0] a, input logic [2:0] lv);
    return iack ? {12'hfff, 4'hf, 12'hfff, lv, 1'b1} : a;
  endfunction
  function automatic logic [7:0] exp_sel(input logic iack, s7,
      input logic [31:0] a, input logic [2:0] lv);
    if (iack) return {!(lv == 7 && s7), 7'h7f};
    case (a[31:16])
      16'h0000: return 8'hfe;
      16'h1000: return 8'hfd;
      16'h2000: return 8'hfb;
      default: return 8'hff;
    endcase
  endfunction
  task automatic op(input logic iack, wr, input logic [1:0] sz,
                    input logic [31:0] a, input logic [2:0] lv);
    logic [31:0] e, w;
    int n;
    w = $urandom;
    while (!req_ready) @(negedge core_clk);
    seen_sel = 8'hff;
    @(posedge core_clk);
    {req_valid, req_iack, req_write, req_size} <= {1'b1, iack, wr, sz};
    {req_addr, req_level, req_fc, req_wdata} <= {a, lv, 4'h5, w};
    {ack_delay, dup_enable, sel7_is_iack} <= 4'($urandom);
    @(posedge core_clk);
    req_valid <= 0;
    for (n = 0; n < 60 && !rsp_valid; n++) @(negedge core_clk);
    e = exp_rdata(iack, sz, a, lv);
    if (!wr || iack) begin
      check("rdata", rsp_rdata, e);
      check("port", rsp_port_size, ack_port);
      check("perr", rsp_parity_err, 0);
    end else
      check("wdata", seen_data[31:16], w[31:16]);
    check("addr", seen_addr, exp_addr(iack, a, lv));
    check("sel", seen_sel, exp_sel(iack, sel7_is_iack, a, lv));
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  task automatic rand_ops(input int cnt);
    repeat (cnt) begin
      k = $urandom % 5;
      op(k == 0, k == 1, 2'($urandom), {k == 2 ? 16'h0 : k == 3 ?
         16'h1000 : k == 4 ? 16'h2000 : 16'($urandom), 16'($urandom)},
         3'($urandom % 7 + 1));
    end
  endtask
  initial begin
    k = $urandom(88765);
    do_reset(0);
    rand_ops(60);
    for (i = 0; i < 14; i++) op(1, 0, 2'h1, 0, 3'(i % 7 + 1));
    do_reset(1);
    rand_ops(30);
    finish_test;
  end
  initial begin
    #100000;
    err_count++;
    finish_test;
  end
endmodule
